// [core/pmcs_top.sv]
// power-mode and clock sequencer with an AXI4-Lite register slave
// assumes async pins arrive raw and are synchronised here; one 200 MHz aclk
// Notes on behaviour
// RULE1 - input divider takes 1 to 256
// RULE2 - multiplier takes 1 to 32768
// RULE3 - software keeps oscillator between 275 and 550 MHz
// RULE4 - reset and power-down disable and bypass synthesizer
// RULE5 - software configures, enables, waits lock, connects
// RULE6 - start and pdown wake run from RC
// RULE7 - wake timer qualifies crystal oscillator before use
// RULE8 - idle stops processor, peripherals keep running
// RULE9 - sleep stops oscillator and all internal clocks
// RULE10 - sleep gates RC output, RTC oscillator runs
// RULE11 - sleep clears synthesizer and both dividers
// RULE12 - sleep ends on reset/irq, flash stays powered
// RULE13 - sleep wake waits 4 RC or 4096 cycles
// RULE14 - software reprograms clocks after waking
// RULE15 - power-down also switches off RC and flash
// RULE16 - pdown wake: 60 us then 4 RC cycles
// RULE17 - flash blocked until 100 us RC timer expires
// RULE18 - deep power-down exit equals full reset
// RULE19 - deep power-down wakes on alarm or reset
// RULE20 - each peripheral has gate and divider
// RULE21 - RTC alarm drives power-restore output
// RULE22 - internal reset held until all conditions met
// RULE23 - connect refused while lock flag clear
`timescale 1ns/100ps
module pmcs_top #(
  parameter int NPER = 8,
  parameter int IRC_START_CYC = pmcs_pkg::IRC_START_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset_n,
  input wire logic wake_irq,
  input wire logic rtc_alarm,
  input wire logic pll_lock_pin,
  input wire logic main_osc_clk,
  output logic sys_reset_n,
  output logic cpu_clock_en,
  output logic [pmcs_pkg::N_W-1:0] pll_n_m1,
  output logic [pmcs_pkg::M_W-1:0] pll_m_m1,
  output logic pll_enable,
  output logic pll_bypass,
  output logic [1:0] clk_src,
  output logic [7:0] cpu_div,
  output logic [7:0] usb_div,
  output logic main_osc_run,
  output logic internal_rc_osc_out_en,
  output logic internal_rc_osc_power,
  output logic rtc_osc_run,
  output logic flash_power,
  output logic flash_access_en,
  output logic main_domain_power,
  output logic power_restore_alarm,
  output logic [NPER-1:0] periph_clk_en
);
  localparam int CW = 16;
  pmcs_pkg::pmcs_state_e state_reg;
  logic [pmcs_pkg::SY_N-1:0] sy1_reg, sy2_reg;
  logic ext_rst_s, wake_s, alarm_s, lock_s, osc_edge, osc_prev_reg;
  logic irc_tick, irc_on, wipe, dpd_exit, wake_main_reg, mode_req;
  logic [6:0] irc_div_reg;
  logic [CW-1:0] cnt_reg, fcnt_reg, ocnt_reg;
  logic flash_ok_reg, osc_ok_reg, pll_en_reg, pll_conn_reg, osc_en_reg;
  logic [pmcs_pkg::N_W+pmcs_pkg::M_W-1:0] cfg_reg;
  logic [NPER-1:0] gate_reg;
  logic [pmcs_pkg::PDIV_W*NPER-1:0] pdiv_reg;
  logic aw_hold, w_hold;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic do_wr, rd_ok;
  pmcs_pclk_if #(.NPER(NPER)) pif ();

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        r[b*8 +: 8] = n[b*8 +: 8];
    return r;
  endfunction

  function automatic logic known(input logic [11:0] a);
    return a == pmcs_pkg::ADR_MODE || a == pmcs_pkg::ADR_PLL_CFG ||
           a == pmcs_pkg::ADR_PLL_CTRL || a == pmcs_pkg::ADR_STATUS ||
           a == pmcs_pkg::ADR_CLK_SRC || a == pmcs_pkg::ADR_CPU_DIV ||
           a == pmcs_pkg::ADR_PGATE || a == pmcs_pkg::ADR_PDIV;
  endfunction

  // two-flop synchronisers; only the second stage is read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sy1_reg <= '0;
      sy2_reg <= '0;
      osc_prev_reg <= 1'b0;
    end
    else
    begin
      sy1_reg <= {main_osc_clk, pll_lock_pin, rtc_alarm, wake_irq, ext_reset_n};
      sy2_reg <= sy1_reg;
      osc_prev_reg <= sy2_reg[pmcs_pkg::SY_OSC];
    end
  end
  assign ext_rst_s = sy2_reg[pmcs_pkg::SY_EXTRST];
  assign wake_s = sy2_reg[pmcs_pkg::SY_WAKE];
  assign alarm_s = sy2_reg[pmcs_pkg::SY_ALARM];
  assign lock_s = sy2_reg[pmcs_pkg::SY_LOCK];
  assign osc_edge = sy2_reg[pmcs_pkg::SY_OSC] && !osc_prev_reg;

  // leaving deep power-down retains nothing: same path as a chip reset
  assign dpd_exit = (state_reg == pmcs_pkg::ST_DPD) && alarm_s; // RULE19
  assign wipe = !aresetn || !ext_rst_s || dpd_exit; // RULE18

  // rc output is gated in sleep, power-down and deep power-down and while it restarts
  assign irc_on = !(state_reg inside {pmcs_pkg::ST_SLEEP, pmcs_pkg::ST_PDOWN,
                    pmcs_pkg::ST_DPD, pmcs_pkg::ST_WAKE_IRC}); // RULE10

  // 4 MHz rc cycle as an enable pulse
  always_ff @(posedge aclk)
  begin
    if (wipe || !irc_on)
      irc_div_reg <= '0;
    else if (irc_div_reg == 7'(pmcs_pkg::IRC_DIV - 1))
      irc_div_reg <= '0;
    else
      irc_div_reg <= irc_div_reg + 7'h01;
  end
  assign irc_tick = irc_on && (irc_div_reg == 7'(pmcs_pkg::IRC_DIV - 1));

  // mode sequencer
  always_ff @(posedge aclk)
  begin
    if (wipe)
    begin
      state_reg <= pmcs_pkg::ST_RESET;
      cnt_reg <= '0;
      wake_main_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        pmcs_pkg::ST_RESET:
        begin
          // external reset released (wipe), fixed count, flash ready
          if (cnt_reg >= CW'(pmcs_pkg::RST_IRC_CYC) && flash_ok_reg)
            state_reg <= pmcs_pkg::ST_RUN; // RULE22
          else if (irc_tick && cnt_reg < CW'(pmcs_pkg::RST_IRC_CYC))
            cnt_reg <= cnt_reg + CW'(1);
        end
        pmcs_pkg::ST_RUN:
        begin
          cnt_reg <= '0;
          if (mode_req)
            case (wdata_q[2:0])
              pmcs_pkg::MODE_IDLE: state_reg <= pmcs_pkg::ST_IDLE;
              pmcs_pkg::MODE_SLEEP: state_reg <= pmcs_pkg::ST_SLEEP;
              pmcs_pkg::MODE_PDOWN: state_reg <= pmcs_pkg::ST_PDOWN;
              pmcs_pkg::MODE_DPD: state_reg <= pmcs_pkg::ST_DPD;
              default: state_reg <= pmcs_pkg::ST_RUN;
            endcase
          wake_main_reg <= (clk_src == pmcs_pkg::SRC_MAIN);
        end
        pmcs_pkg::ST_IDLE:
          if (wake_s || alarm_s)
            state_reg <= pmcs_pkg::ST_RUN; // RULE8
        pmcs_pkg::ST_SLEEP:
          if (wake_s || alarm_s)
            state_reg <= pmcs_pkg::ST_WAKE_CNT; // RULE12
        pmcs_pkg::ST_PDOWN:
          if (wake_s || alarm_s)
          begin
            state_reg <= pmcs_pkg::ST_WAKE_IRC;
            wake_main_reg <= 1'b0; // RULE6
          end
        pmcs_pkg::ST_WAKE_IRC:
        begin
          // rc start-up time, counted in aclk cycles
          if (cnt_reg == CW'(IRC_START_CYC - 1))
          begin
            cnt_reg <= '0;
            state_reg <= pmcs_pkg::ST_WAKE_CNT; // RULE16
          end
          else
            cnt_reg <= cnt_reg + CW'(1);
        end
        pmcs_pkg::ST_WAKE_CNT:
        begin
          if (wake_main_reg ? osc_edge : irc_tick)
          begin
            if (cnt_reg == (wake_main_reg ? CW'(pmcs_pkg::SLEEP_OSC_CYC - 1)
                                          : CW'(pmcs_pkg::SLEEP_IRC_CYC - 1)))
              state_reg <= pmcs_pkg::ST_RUN; // RULE13
            else
              cnt_reg <= cnt_reg + CW'(1);
          end
        end
        // only an alarm or a reset leaves, and both go through the wipe path
        pmcs_pkg::ST_DPD: state_reg <= pmcs_pkg::ST_DPD; // RULE19
        default: state_reg <= pmcs_pkg::ST_RESET;
      endcase
    end
  end

  // flash wake-up timer, restarted whenever flash power is dropped
  always_ff @(posedge aclk)
  begin
    if (wipe || !flash_power)
    begin
      fcnt_reg <= '0;
      flash_ok_reg <= 1'b0;
    end
    else if (irc_tick && !flash_ok_reg)
    begin
      if (fcnt_reg == CW'(pmcs_pkg::FLASH_IRC_CYC - 1))
        flash_ok_reg <= 1'b1; // RULE17
      fcnt_reg <= fcnt_reg + CW'(1);
    end
  end

  // crystal wake-up timer: counts oscillator edges once it is started
  always_ff @(posedge aclk)
  begin
    if (wipe || !main_osc_run)
    begin
      ocnt_reg <= '0;
      osc_ok_reg <= 1'b0;
    end
    else if (osc_edge && !osc_ok_reg)
    begin
      if (ocnt_reg == CW'(pmcs_pkg::OSC_WAKE_CYC - 1))
        osc_ok_reg <= 1'b1; // RULE7
      ocnt_reg <= ocnt_reg + CW'(1);
    end
  end

  // axi write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign do_wr = aw_hold && w_hold && !s_axi_bvalid;
  assign mode_req = do_wr && awaddr_q == pmcs_pkg::ADR_MODE && state_reg == pmcs_pkg::ST_RUN;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmcs_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(awaddr_q) ? pmcs_pkg::RESP_OKAY : pmcs_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // software-owned clock registers; sleep and power-down clear synthesizer enable, connect and both dividers
  always_ff @(posedge aclk)
  begin
    if (wipe)
    begin
      pll_en_reg <= 1'b0; // RULE4
      pll_conn_reg <= 1'b0;
      osc_en_reg <= 1'b0;
      cfg_reg <= '0;
      clk_src <= pmcs_pkg::SRC_IRC; // RULE6
      cpu_div <= '0;
      usb_div <= '0;
      gate_reg <= '0;
      pdiv_reg <= '0;
    end
    else if (state_reg inside {pmcs_pkg::ST_SLEEP, pmcs_pkg::ST_PDOWN})
    begin
      pll_en_reg <= 1'b0; // RULE11
      pll_conn_reg <= 1'b0;
      cpu_div <= '0;
      usb_div <= '0;
      if (state_reg == pmcs_pkg::ST_PDOWN)
      begin
        osc_en_reg <= 1'b0; // RULE4
        clk_src <= pmcs_pkg::SRC_IRC;
      end
    end
    else if (do_wr)
    begin
      case (awaddr_q)
        pmcs_pkg::ADR_PLL_CFG: cfg_reg <= 23'(merge(32'(cfg_reg), wdata_q, wstrb_q)); // RULE1 RULE2
        pmcs_pkg::ADR_PLL_CTRL:
          if (wstrb_q[0])
          begin
            pll_en_reg <= wdata_q[pmcs_pkg::CTRL_EN];
            osc_en_reg <= wdata_q[pmcs_pkg::CTRL_OSC];
            // connecting an unlocked synthesizer is refused
            pll_conn_reg <= wdata_q[pmcs_pkg::CTRL_CONN] && wdata_q[pmcs_pkg::CTRL_EN]
                            && lock_s; // RULE23
          end
        pmcs_pkg::ADR_CLK_SRC:
          if (wstrb_q[0] && wdata_q[1:0] != 2'h3)
            clk_src <= wdata_q[1:0];
        pmcs_pkg::ADR_CPU_DIV:
        begin
          if (wstrb_q[0])
            cpu_div <= wdata_q[7:0];
          if (wstrb_q[1])
            usb_div <= wdata_q[pmcs_pkg::DIV_USB_LSB +: 8];
        end
        pmcs_pkg::ADR_PGATE: gate_reg <= NPER'(merge(32'(gate_reg), wdata_q, wstrb_q));
        pmcs_pkg::ADR_PDIV:
          pdiv_reg <= (pmcs_pkg::PDIV_W * NPER)'(merge(32'(pdiv_reg), wdata_q, wstrb_q));
        default: ;
      endcase
    end
    else if (!pll_en_reg || !lock_s)
      pll_conn_reg <= 1'b0; // losing lock drops the connection too
  end

  // read mux; status shows live sequencer state
  always_comb
  begin
    rd_word = '0;
    rd_ok = known(s_axi_araddr);
    case ({s_axi_araddr[11:2], 2'h0})
      pmcs_pkg::ADR_MODE: rd_word = 32'(state_reg);
      pmcs_pkg::ADR_PLL_CFG: rd_word = 32'(cfg_reg);
      pmcs_pkg::ADR_PLL_CTRL: rd_word = 32'({osc_en_reg, pll_conn_reg, pll_en_reg});
      pmcs_pkg::ADR_STATUS:
        rd_word = {16'h0000, state_reg, 3'h0, flash_ok_reg, osc_ok_reg, pll_conn_reg,
                   pll_en_reg, lock_s}; // RULE23
      pmcs_pkg::ADR_CLK_SRC: rd_word = 32'(clk_src);
      pmcs_pkg::ADR_CPU_DIV: rd_word = {16'h0000, usb_div, cpu_div};
      pmcs_pkg::ADR_PGATE: rd_word = 32'(gate_reg);
      pmcs_pkg::ADR_PDIV: rd_word = 32'(pdiv_reg);
      default: rd_word = '0;
    endcase
  end

  // read channel: one cycle to answer
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pmcs_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? pmcs_pkg::RESP_OKAY : pmcs_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // peripheral clocks run in run and idle only
  assign pif.gate = gate_reg;
  assign pif.divsel = pdiv_reg;
  assign pif.run = state_reg inside {pmcs_pkg::ST_RUN, pmcs_pkg::ST_IDLE}; // RULE8 RULE9
  assign periph_clk_en = pif.clk_en;
  pmcs_pclk_div #(.NPER(NPER)) u_pdiv (.aclk(aclk), .aresetn(aresetn), .p(pif.div));

  // power and clock outputs
  assign sys_reset_n = state_reg != pmcs_pkg::ST_RESET; // RULE22
  assign cpu_clock_en = state_reg == pmcs_pkg::ST_RUN; // RULE8
  assign pll_n_m1 = cfg_reg[pmcs_pkg::N_W-1:0];
  assign pll_m_m1 = cfg_reg[pmcs_pkg::CFG_M_LSB +: pmcs_pkg::M_W];
  assign pll_enable = pll_en_reg;
  assign pll_bypass = !pll_conn_reg;
  assign main_osc_run = osc_en_reg && irc_on && state_reg != pmcs_pkg::ST_RESET; // RULE9
  assign internal_rc_osc_out_en = irc_on;
  assign internal_rc_osc_power = !(state_reg inside {pmcs_pkg::ST_PDOWN, pmcs_pkg::ST_DPD}); // RULE15
  assign rtc_osc_run = 1'b1; // RULE10
  assign flash_power = internal_rc_osc_power; // RULE12 RULE15
  assign flash_access_en = flash_ok_reg; // RULE17
  assign main_domain_power = state_reg != pmcs_pkg::ST_DPD;
  // the alarm stays usable while the main domain is off
  assign power_restore_alarm = alarm_s; // RULE21

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_enter_sleep;
    state_reg != pmcs_pkg::ST_SLEEP ##1 state_reg == pmcs_pkg::ST_SLEEP;
  endsequence
  sequence s_irc_last;
    state_reg == pmcs_pkg::ST_WAKE_CNT && !wake_main_reg && irc_tick &&
    cnt_reg == CW'(pmcs_pkg::SLEEP_IRC_CYC - 1);
  endsequence
  property p_sleep_clear;
    s_enter_sleep |=> !pll_en_reg && cpu_div == 8'h00 && usb_div == 8'h00;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("sleep kept clocks"); // RULE11
  property p_wake_irc;
    s_irc_last |=> state_reg == pmcs_pkg::ST_RUN && cpu_clock_en;
  endproperty
  a_wake_irc: assert property (p_wake_irc) else $error("rc wake count wrong"); // RULE13
  property p_conn_lock;
    $rose(pll_conn_reg) |-> $past(lock_s) && pll_en_reg;
  endproperty
  a_conn_lock: assert property (p_conn_lock) else $error("unlocked connect"); // RULE23
  property p_pdown_off;
    state_reg == pmcs_pkg::ST_PDOWN |-> (!flash_power && !internal_rc_osc_power)
      ##1 (!pll_en_reg && pll_bypass);
  endproperty
  a_pdown_off: assert property (p_pdown_off) else $error("pdown left power on"); // RULE15
  property p_sleep_gate;
    state_reg == pmcs_pkg::ST_SLEEP |-> !internal_rc_osc_out_en && internal_rc_osc_power
      && flash_power && periph_clk_en == '0;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep gating wrong"); // RULE9
  property p_flash_time;
    $rose(flash_ok_reg) |-> $past(fcnt_reg) == CW'(pmcs_pkg::FLASH_IRC_CYC - 1);
  endproperty
  a_flash_time: assert property (p_flash_time) else $error("flash timer early"); // RULE17
  property p_rst_hold;
    !ext_rst_s |=> !sys_reset_n;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset released early"); // RULE22
  property p_dpd_stay;
    state_reg == pmcs_pkg::ST_DPD && !alarm_s && ext_rst_s |=> state_reg == pmcs_pkg::ST_DPD;
  endproperty
  a_dpd_stay: assert property (p_dpd_stay) else $error("dpd woke wrongly"); // RULE19
  property p_idle_run;
    state_reg == pmcs_pkg::ST_IDLE && !wake_s && !alarm_s |=> !cpu_clock_en ##0 pif.run;
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("idle gating wrong"); // RULE8
endmodule // pmcs_top

// [common/pmcs_pkg.sv]
// power-mode and clock sequencer: register map, field layout, timing constants
// assumes a 200 MHz aclk; IRC_DIV and IRC_START_CYC_DEF are derived from it
package pmcs_pkg;
  localparam logic [11:0] ADR_MODE = 12'h000;
  localparam logic [11:0] ADR_PLL_CFG = 12'h004;
  localparam logic [11:0] ADR_PLL_CTRL = 12'h008;
  localparam logic [11:0] ADR_STATUS = 12'h00C;
  localparam logic [11:0] ADR_CLK_SRC = 12'h010;
  localparam logic [11:0] ADR_CPU_DIV = 12'h014;
  localparam logic [11:0] ADR_PGATE = 12'h018;
  localparam logic [11:0] ADR_PDIV = 12'h01C;
  localparam logic [2:0] MODE_IDLE = 3'h1;
  localparam logic [2:0] MODE_SLEEP = 3'h2;
  localparam logic [2:0] MODE_PDOWN = 3'h3;
  localparam logic [2:0] MODE_DPD = 3'h4;
  localparam logic [1:0] SRC_IRC = 2'h0;
  localparam logic [1:0] SRC_MAIN = 2'h1;
  localparam logic [1:0] SRC_RTC = 2'h2;
  localparam int N_W = 8;
  localparam int M_W = 15;
  localparam int CFG_M_LSB = 8;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CONN = 1;
  localparam int CTRL_OSC = 2;
  localparam int DIV_USB_LSB = 8;
  localparam int PDIV_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // synchroniser lanes
  localparam int SY_EXTRST = 0;
  localparam int SY_WAKE = 1;
  localparam int SY_ALARM = 2;
  localparam int SY_LOCK = 3;
  localparam int SY_OSC = 4;
  localparam int SY_N = 5;
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int IRC_PERIOD_NS = 250;
  localparam int IRC_DIV = IRC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int IRC_START_US = 60;
  localparam int IRC_START_CYC_DEF = (IRC_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_WAKE_US = 100;
  localparam int FLASH_IRC_CYC = (FLASH_WAKE_US * 1000 + IRC_PERIOD_NS - 1) / IRC_PERIOD_NS;
  localparam int SLEEP_IRC_CYC = 4;
  localparam int SLEEP_OSC_CYC = 4096;
  localparam int PD_IRC_CYC = 4;
  localparam int RST_IRC_CYC = 4;
  localparam int OSC_WAKE_CYC = 4096;
  typedef enum logic [7:0] {
    ST_RESET = 8'h01, ST_RUN = 8'h02, ST_IDLE = 8'h04, ST_SLEEP = 8'h08,
    ST_PDOWN = 8'h10, ST_DPD = 8'h20, ST_WAKE_IRC = 8'h40, ST_WAKE_CNT = 8'h80
  } pmcs_state_e;
endpackage

// [common/pmcs_pclk_if.sv]
// carrier between the sequencer and its peripheral clock divider bank
// assumes both ends share aclk
`timescale 1ns/100ps
interface pmcs_pclk_if #(parameter int NPER = 8);
  logic [NPER-1:0] gate;
  logic [pmcs_pkg::PDIV_W*NPER-1:0] divsel;
  logic run;
  logic [NPER-1:0] clk_en;
  modport ctl (output gate, output divsel, output run, input clk_en);
  modport div (input gate, input divsel, input run, output clk_en);
endinterface

// [core/pmcs_pclk_div.sv]
// per-peripheral clock gate and divider, one enable pulse stream per peripheral
// assumes gate/divsel come from registers in the aclk domain
`timescale 1ns/100ps
module pmcs_pclk_div #(
  parameter int NPER = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  pmcs_pclk_if.div p
);
  localparam int CW = 3;
  genvar i;
  generate
    for (i = 0; i < NPER; i++)
    begin : g_per
      logic [CW-1:0] cnt_reg;
      logic [pmcs_pkg::PDIV_W-1:0] sel;
      logic [CW-1:0] lim;
      assign sel = p.divsel[i*pmcs_pkg::PDIV_W +: pmcs_pkg::PDIV_W];
      // divide by 1, 2, 4 or 8; a gated peripheral sees no enable at all
      assign lim = CW'((1 << sel) - 1);
      always_ff @(posedge aclk)
      begin
        if (!aresetn || !p.run || !p.gate[i])
          cnt_reg <= '0;
        else if (cnt_reg >= lim)
          cnt_reg <= '0;
        else
          cnt_reg <= cnt_reg + CW'(1);
      end
      assign p.clk_en[i] = p.run && p.gate[i] && (cnt_reg >= lim); // RULE20
    end
  endgenerate
endmodule // pmcs_pclk_div

// [tb/pmcs_top_tb.sv]
// bench for the power-mode and clock sequencer: AXI4-Lite tasks and mode walks
// assumes the design package is compiled first; async pins are driven from aclk
`timescale 1ns/100ps
module pmcs_top_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, wake_irq, lock, sys_reset_n, cpu_clock_en, pll_enable, pll_bypass;
  logic mrun, rc_en, rc_pw, rtc_run, fl_pw, fl_en, md_pw, alarm_out, ext_rst_n, alarm;
  logic [2:0] oc = 3'h0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, clk_src;
  logic [7:0] n_m1, cpu_div, usb_div, pce, acc;
  logic [14:0] m_m1;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  pmcs_top #(.NPER(8), .IRC_START_CYC(20)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_reset_n(ext_rst_n), .wake_irq(wake_irq), .rtc_alarm(alarm), .pll_lock_pin(lock),
    .main_osc_clk(oc[2]), .sys_reset_n(sys_reset_n), .cpu_clock_en(cpu_clock_en),
    .pll_n_m1(n_m1), .pll_m_m1(m_m1), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
    .clk_src(clk_src), .cpu_div(cpu_div), .usb_div(usb_div), .main_osc_run(mrun),
    .internal_rc_osc_out_en(rc_en), .internal_rc_osc_power(rc_pw), .rtc_osc_run(rtc_run),
    .flash_power(fl_pw), .flash_access_en(fl_en), .main_domain_power(md_pw),
    .power_restore_alarm(alarm_out), .periph_clk_en(pce));
  // 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // main oscillator stand-in: one pulse every 5 aclk, slower than aclk/4
  always @(posedge aclk) oc <= (oc == 3'h4) ? 3'h0 : oc + 3'h1;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // write: both channels offered together, each released when taken
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    // ready is looked at on the falling edge, where it has settled
    while (pa || pw)
    begin
      @(negedge aclk);
      ta = pa && awready === 1'b1;
      tw = pw && wready === 1'b1;
      @(posedge aclk);
      if (ta) begin awvalid <= 1'b0; pa = 1'b0; end
      if (tw) begin wvalid <= 1'b0; pw = 1'b0; end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [11:0] a);
    araddr <= a; arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask
  // bounded wait for sys_reset_n (0), cpu_clock_en (1) or flash_access_en (2)
  task automatic wt(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(negedge aclk);
      if ((sel == 0 ? sys_reset_n : sel == 1 ? cpu_clock_en : fl_en) === 1'b1) break;
    end
    @(posedge aclk);
    if (i == lim) chk("wait", 0, 1);
  endtask
  task automatic mode(input logic [2:0] m);
    axw(pmcs_pkg::ADR_MODE, {29'h0, m});
    repeat (4) @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog: four 20000-cycle waits plus traffic fit inside this
  initial
  begin
    repeat (100000) @(posedge aclk);
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    // response ready stays high throughout, so no task toggles it between calls
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b1; arvalid = 1'b0;
    rready = 1'b1; awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; wstrb = 4'hF;
    wake_irq = 1'b0; lock = 1'b0; ext_rst_n = 1'b1; alarm = 1'b0;
    repeat (2) @(posedge aclk);
    chk("bypass", pll_bypass, 1);
    chk("pll_en", pll_enable, 0);
    chk("src", clk_src, pmcs_pkg::SRC_IRC);
    chk("sysrst", sys_reset_n, 0);
    aresetn <= 1'b1;
    wt(0, 25000);
    chk("flash_en", fl_en, 1);
    $display("test reset done");
    axw(pmcs_pkg::ADR_PLL_CFG, 32'h007F_FFFF);
    chk("wr_resp", r, pmcs_pkg::RESP_OKAY);
    chk("n", n_m1, 8'hFF);
    chk("m", m_m1, 15'h7FFF);
    axr(pmcs_pkg::ADR_PLL_CFG);
    chk("cfg", d, 32'h007F_FFFF);
    axr(12'h020);
    chk("unmapped", r, pmcs_pkg::RESP_SLVERR);
    axw(pmcs_pkg::ADR_PLL_CTRL, 32'h3);
    chk("no_conn", pll_bypass, 1);
    lock <= 1'b1;
    repeat (4) @(posedge aclk);
    axw(pmcs_pkg::ADR_PLL_CTRL, 32'h3);
    chk("conn", {pll_enable, pll_bypass}, 2'b10);
    $display("test pll done");
    axw(pmcs_pkg::ADR_PGATE, 32'hFF);
    mode(pmcs_pkg::MODE_IDLE);
    chk("idle_cpu", cpu_clock_en, 0);
    acc = 8'h00;
    repeat (16) @(posedge aclk) acc |= pce;
    chk("idle_pclk", acc, 8'hFF);
    wake_irq <= 1'b1;
    wt(1, 50);
    wake_irq <= 1'b0;
    axw(pmcs_pkg::ADR_PDIV, 32'h3);
    n = 0;
    repeat (16) @(negedge aclk) n += pce[0];
    @(posedge aclk);
    chk("div8", n, 2);
    axw(pmcs_pkg::ADR_PGATE, 32'h00);
    acc = 8'h00;
    repeat (16) @(posedge aclk) acc |= pce;
    chk("gated", acc, 8'h00);
    $display("test idle done");
    axw(pmcs_pkg::ADR_CPU_DIV, 32'h0305);
    mode(pmcs_pkg::MODE_SLEEP);
    chk("sl_pll", {pll_enable, pll_bypass}, 2'b01);
    chk("sl_div", {cpu_div, usb_div}, 16'h0);
    chk("sl_clk", {cpu_clock_en, mrun, rc_en}, 3'b000);
    chk("sl_pw", {rc_pw, rtc_run, fl_pw, md_pw}, 4'hF);
    wake_irq <= 1'b1;
    wt(1, 400);
    wake_irq <= 1'b0;
    chk("wk_div", {cpu_div, pll_enable}, 9'h0);
    axw(pmcs_pkg::ADR_CPU_DIV, 32'h0305);
    chk("rediv", cpu_div, 8'h05);
    $display("test sleep done");
    mode(pmcs_pkg::MODE_PDOWN);
    chk("pd_pw", {rc_pw, fl_pw, pll_bypass, cpu_div}, 11'h100);
    wake_irq <= 1'b1;
    wt(1, 600);
    wake_irq <= 1'b0;
    chk("pd_src", clk_src, pmcs_pkg::SRC_IRC);
    chk("pd_flash", fl_en, 0);
    axw(pmcs_pkg::ADR_PLL_CTRL, 32'h4);
    axr(pmcs_pkg::ADR_STATUS);
    chk("osc_early", {mrun, d[3]}, 2'b10);
    wt(2, 21000);
    repeat (1500) @(posedge aclk);
    axr(pmcs_pkg::ADR_STATUS);
    chk("osc_ok", d[4:3], 2'b11);
    $display("test pdown done");
    axw(pmcs_pkg::ADR_CLK_SRC, 32'h1);
    mode(pmcs_pkg::MODE_SLEEP);
    wake_irq <= 1'b1;
    repeat (1000) @(posedge aclk);
    chk("osc_wait", cpu_clock_en, 0);
    wake_irq <= 1'b0;
    wt(1, 21000);
    $display("test osc wake done");
    mode(pmcs_pkg::MODE_DPD);
    wake_irq <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("dpd_stay", {md_pw, sys_reset_n}, 2'b01);
    wake_irq <= 1'b0;
    alarm <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("dpd_wake", {alarm_out, sys_reset_n, md_pw, clk_src}, 5'h14);
    alarm <= 1'b0;
    wt(0, 25000);
    ext_rst_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("ext_rst", {sys_reset_n, pll_bypass}, 2'b01);
    ext_rst_n <= 1'b1;
    $display("test dpd done");
    tally_and_finish;
  end
endmodule // pmcs_top_tb
